/* File: rtl/cft_defines.svh */
// register map, field positions, reset values and frame counts of the trim register bank
`ifndef CFT_DEFINES_SVH
`define CFT_DEFINES_SVH
`define CFT_ADDR_SUM    7'h06
`define CFT_ADDR_CTRL   7'h07
`define CFT_ADDR_LOW    7'h08
`define CFT_ADDR_HIGH   7'h09
`define CFT_ADDR_CSET   7'h0a
`define CFT_ADDR_SSFM   7'h0b
`define CFT_CTRL_WP     0
`define CFT_CTRL_RST    1
`define CFT_CTRL_FAULT  2
`define CFT_SUM_DIR     0
`define CFT_DAC_RESET   7'h00
`define CFT_CSET_RESET  5'h00
`define CFT_SSFM_RESET  5'h00
`define CFT_CSET_BASE   5'h10
`define CFT_PEC_POLY    8'h07
`define CFT_CMD_LAST    5'h07
`define CFT_RD_LOAD     5'h0f
`define CFT_FRAME_LAST  5'h17
`define CFT_FRAME_BITS  5'h18
`endif

/* File: rtl/cft_pkg.sv */
// state types of the trim register bank
package cft_pkg;
    typedef struct packed {
        logic       wrSeen;
        logic       rdSeen;
        logic       wp;
        logic       commFault;
        logic [6:0] lowDac;
        logic [6:0] highDac;
        logic [4:0] currentSet;
        logic [4:0] ssfm;
        logic [7:0] readHold;
        logic [7:0] lowCur;
        logic       lowEn;
        logic [7:0] highCur;
        logic       highEn;
        logic [4:0] currentSetUa;
        logic [3:0] spreadPct;
        logic [3:0] modDivExp;
    } cft_regs_t;
    typedef struct packed {
        logic [4:0] cnt;
        logic [7:0] cmd;
        logic [7:0] data;
        logic [7:0] pec;
        logic [7:0] crc;
        logic [7:0] outSh;
        logic       sdo;
        logic       oe_n;
    } cft_frame_t;
    typedef struct packed {
        logic       wrTgl;
        logic       rdTgl;
        logic [6:0] wrAddr;
        logic [7:0] wrData;
        logic       wrBad;
        logic [6:0] rdAddr;
    } cft_link_t;
endpackage

/* File: rtl/cft_sync.sv */
// two-flop synchroniser for levels and toggles
`timescale 1ns/1ns
module cft_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } cft_sync_t;
    cft_sync_t sync_r;
    cft_sync_t sync_nxt;
    always_comb begin
        sync_nxt.s1 = d;
        sync_nxt.s2 = sync_r.s1;
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sync_r <= '0;
        end else begin
            sync_r <= sync_nxt;
        end
    end
    assign q = sync_r.s2;
endmodule

/* File: rtl/cft_serial.sv */
// serial port frame logic on the link clock
`timescale 1ns/1ns
`include "cft_defines.svh"
module cft_serial (
    input  wire logic       sck,
    input  wire logic       rst_n,
    input  wire logic       chipSel_n,
    input  wire logic       sdi,
    input  wire logic [7:0] readHold,
    output logic            sdo,
    output logic            sdoOe_n,
    output logic            wrTgl,
    output logic            rdTgl,
    output logic      [6:0] wrAddr,
    output logic      [7:0] wrData,
    output logic            wrBad,
    output logic      [6:0] rdAddr
);
    cft_pkg::cft_frame_t frame_r;
    cft_pkg::cft_frame_t frame_nxt;
    cft_pkg::cft_link_t  link_r;
    cft_pkg::cft_link_t  link_nxt;

    function automatic logic [7:0] crcStep(input logic [7:0] c, input logic b);
        crcStep = {c[6:0], 1'b0} ^ ((c[7] ^ b) ? `CFT_PEC_POLY : 8'h00);
    endfunction

    always_comb begin
        frame_nxt = frame_r;
        link_nxt = link_r;
        frame_nxt.oe_n = 1'b0;
        if (frame_r.cnt < `CFT_FRAME_BITS) begin
            frame_nxt.cnt = frame_r.cnt + 5'h01;
        end
        if (frame_r.cnt <= `CFT_CMD_LAST) begin
            frame_nxt.cmd = {frame_r.cmd[6:0], sdi};
        end else if (frame_r.cnt <= `CFT_RD_LOAD) begin
            frame_nxt.data = {frame_r.data[6:0], sdi};
        end else begin
            frame_nxt.pec = {frame_r.pec[6:0], sdi};
        end
        if (frame_r.cnt <= `CFT_RD_LOAD) begin
            frame_nxt.crc = crcStep(frame_r.crc, sdi);
        end
        // read command: ask the register side for the byte
        if (frame_r.cnt == `CFT_CMD_LAST && sdi) begin
            link_nxt.rdTgl = ~link_r.rdTgl;
            link_nxt.rdAddr = frame_r.cmd[6:0];
        end
        if (frame_r.cnt == `CFT_RD_LOAD && frame_r.cmd[0]) begin
            frame_nxt.sdo = readHold[7];
            frame_nxt.outSh = {readHold[6:0], 1'b0};
        end else begin
            frame_nxt.sdo = frame_r.outSh[7];
            frame_nxt.outSh = {frame_r.outSh[6:0], 1'b0};
        end
        // write frame complete: hand over address, data and check result
        if (frame_r.cnt == `CFT_FRAME_LAST && !frame_r.cmd[0]) begin
            link_nxt.wrTgl = ~link_r.wrTgl;
            link_nxt.wrAddr = frame_r.cmd[7:1];
            link_nxt.wrData = frame_r.data;
            link_nxt.wrBad = ({frame_r.pec[6:0], sdi} != frame_r.crc);
        end
    end

    // frame state ends with the frame's own select
    always_ff @(posedge sck or posedge chipSel_n) begin
        if (chipSel_n) begin
            frame_r <= '{oe_n: 1'b1, default: '0};
        end else begin
            frame_r <= frame_nxt;
        end
    end

    always_ff @(posedge sck or negedge rst_n) begin
        if (!rst_n) begin
            link_r <= '0;
        end else begin
            link_r <= link_nxt;
        end
    end

    assign sdo = frame_r.sdo;
    assign sdoOe_n = frame_r.oe_n;
    assign wrTgl = link_r.wrTgl;
    assign rdTgl = link_r.rdTgl;
    assign wrAddr = link_r.wrAddr;
    assign wrData = link_r.wrData;
    assign wrBad = link_r.wrBad;
    assign rdAddr = link_r.rdAddr;
endmodule

/* File: rtl/cft_regs.sv */
// configuration summary, chip control, trim and spread registers with serial access
`timescale 1ns/1ns
`include "cft_defines.svh"
module cft_regs (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic sck,
    input  wire logic chipSel_n,
    input  wire logic sdi,
    input  wire logic pulseSkipFlag,
    input  wire logic discontinuousFlag,
    input  wire logic highImpedanceFlag,
    input  wire logic spreadActiveFlag,
    input  wire logic stepDownPin,
    output logic       sdo,
    output logic       sdoOe_n,
    output logic [7:0] lowFeedbackPinUa,
    output logic       lowFeedbackPinEn,
    output logic [7:0] highFeedbackPinUa,
    output logic       highFeedbackPinEn,
    output logic [4:0] currentSetPinUa,
    output logic [3:0] spreadPct,
    output logic [3:0] modDivExp,
    output logic       commFaultFlag
);
    cft_pkg::cft_regs_t regs_r;
    cft_pkg::cft_regs_t regs_nxt;
    cft_pkg::cft_regs_t rstVal;

    localparam logic [4:0] SSFM_RST = `CFT_SSFM_RESET;

    logic       wrTgl;
    logic       rdTgl;
    logic [6:0] wrAddr;
    logic [7:0] wrData;
    logic       wrBad;
    logic [6:0] rdAddr;
    logic [1:0] tglQ;
    logic [4:0] strapQ;
    logic       wrEvt;
    logic       rdEvt;
    logic       goodWr;

    cft_serial u_serial (
        .sck       (sck),
        .rst_n     (rst_n),
        .chipSel_n (chipSel_n),
        .sdi       (sdi),
        .readHold  (regs_r.readHold),
        .sdo       (sdo),
        .sdoOe_n   (sdoOe_n),
        .wrTgl     (wrTgl),
        .rdTgl     (rdTgl),
        .wrAddr    (wrAddr),
        .wrData    (wrData),
        .wrBad     (wrBad),
        .rdAddr    (rdAddr)
    );

    // frame events cross as toggles; address and data stay put meanwhile
    cft_sync #(.W(2)) u_tglSync (
        .clk   (clk),
        .rst_n (rst_n),
        .d     ({wrTgl, rdTgl}),
        .q     (tglQ)
    );

    cft_sync #(.W(5)) u_strapSync (
        .clk   (clk),
        .rst_n (rst_n),
        .d     ({pulseSkipFlag, discontinuousFlag, highImpedanceFlag,
                 spreadActiveFlag, stepDownPin}),
        .q     (strapQ)
    );

    function automatic logic [7:0] dacCur(input logic [6:0] code, input logic en);
        dacCur = en ? {code[6], code} : 8'h00;
    endfunction

    function automatic logic [4:0] csetUa(input logic [4:0] code);
        csetUa = (code[4] ? 5'h00 : `CFT_CSET_BASE) + {1'b0, code[3:0]};
    endfunction

    function automatic logic [3:0] pctOf(input logic [1:0] code);
        case (code)
            2'h0: pctOf = 4'hc;
            2'h1: pctOf = 4'hf;
            2'h2: pctOf = 4'ha;
            default: pctOf = 4'h8;
        endcase
    endfunction

    function automatic logic [3:0] divOf(input logic [2:0] code);
        case (code)
            3'h0: divOf = 4'h9;
            3'h1: divOf = 4'ha;
            3'h2: divOf = 4'hb;
            3'h3: divOf = 4'hc;
            3'h4: divOf = 4'h8;
            3'h5: divOf = 4'h7;
            3'h6: divOf = 4'h6;
            default: divOf = 4'h9;
        endcase
    endfunction

    function automatic logic [7:0] regRead(input logic [6:0] addr, input logic [4:0] straps,
                                           input cft_pkg::cft_regs_t r);
        if (addr == `CFT_ADDR_SUM) begin
            regRead = {3'h0, straps};
        end else if (addr == `CFT_ADDR_CTRL) begin
            regRead = {5'h00, r.commFault, 1'b0, r.wp};
        end else if (addr == `CFT_ADDR_LOW) begin
            regRead = {1'b0, r.lowDac};
        end else if (addr == `CFT_ADDR_HIGH) begin
            regRead = {1'b0, r.highDac};
        end else if (addr == `CFT_ADDR_CSET) begin
            regRead = {3'h0, r.currentSet};
        end else if (addr == `CFT_ADDR_SSFM) begin
            regRead = {3'h0, r.ssfm};
        end else begin
            regRead = 8'h00;
        end
    endfunction

    assign wrEvt = (tglQ[1] != regs_r.wrSeen);
    assign rdEvt = (tglQ[0] != regs_r.rdSeen);
    assign goodWr = wrEvt && !wrBad;

    always_comb begin
        rstVal = '0;
        rstVal.wrSeen = tglQ[1];
        rstVal.rdSeen = tglQ[0];
        rstVal.lowDac = `CFT_DAC_RESET;
        rstVal.highDac = `CFT_DAC_RESET;
        rstVal.currentSet = `CFT_CSET_RESET;
        rstVal.ssfm = `CFT_SSFM_RESET;
        rstVal.currentSetUa = csetUa(`CFT_CSET_RESET);
        rstVal.spreadPct = pctOf(SSFM_RST[4:3]);
        rstVal.modDivExp = divOf(SSFM_RST[2:0]);
    end

    always_comb begin
        regs_nxt = regs_r;
        regs_nxt.wrSeen = tglQ[1];
        regs_nxt.rdSeen = tglQ[0];
        if (goodWr) begin
            if (wrAddr == `CFT_ADDR_CTRL) begin
                regs_nxt.wp = wrData[`CFT_CTRL_WP];
                if (wrData[`CFT_CTRL_FAULT]) begin
                    regs_nxt.commFault = 1'b0;
                end
                if (wrData[`CFT_CTRL_RST]) begin
                    regs_nxt.wp = 1'b0;
                    regs_nxt.lowDac = `CFT_DAC_RESET;
                    regs_nxt.highDac = `CFT_DAC_RESET;
                    regs_nxt.currentSet = `CFT_CSET_RESET;
                    regs_nxt.ssfm = `CFT_SSFM_RESET;
                end
            end else if (wrAddr == `CFT_ADDR_LOW && !regs_r.wp) begin
                regs_nxt.lowDac = wrData[6:0];
            end else if (wrAddr == `CFT_ADDR_HIGH && !regs_r.wp) begin
                regs_nxt.highDac = wrData[6:0];
            end else if (wrAddr == `CFT_ADDR_CSET && !regs_r.wp) begin
                regs_nxt.currentSet = wrData[4:0];
            end else if (wrAddr == `CFT_ADDR_SSFM && !regs_r.wp) begin
                regs_nxt.ssfm = wrData[4:0];
            end
        end
        // a new check failure beats a clear in the same cycle
        if (wrEvt && wrBad) begin
            regs_nxt.commFault = 1'b1;
        end
        if (rdEvt) begin
            regs_nxt.readHold = regRead(rdAddr, strapQ, regs_r);
        end
        regs_nxt.lowEn = strapQ[`CFT_SUM_DIR];
        regs_nxt.lowCur = dacCur(regs_r.lowDac, strapQ[`CFT_SUM_DIR]);
        regs_nxt.highEn = !strapQ[`CFT_SUM_DIR];
        regs_nxt.highCur = dacCur(regs_r.highDac, !strapQ[`CFT_SUM_DIR]);
        regs_nxt.currentSetUa = csetUa(regs_r.currentSet);
        regs_nxt.spreadPct = pctOf(regs_r.ssfm[4:3]);
        regs_nxt.modDivExp = divOf(regs_r.ssfm[2:0]);
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            regs_r <= rstVal;
        end else begin
            regs_r <= regs_nxt;
        end
    end

    assign lowFeedbackPinUa = regs_r.lowCur;
    assign lowFeedbackPinEn = regs_r.lowEn;
    assign highFeedbackPinUa = regs_r.highCur;
    assign highFeedbackPinEn = regs_r.highEn;
    assign currentSetPinUa = regs_r.currentSetUa;
    assign spreadPct = regs_r.spreadPct;
    assign modDivExp = regs_r.modDivExp;
    assign commFaultFlag = regs_r.commFault;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    logic wrLow;
    logic wrCtrl;
    assign wrLow = goodWr && wrAddr == `CFT_ADDR_LOW;
    assign wrCtrl = goodWr && wrAddr == `CFT_ADDR_CTRL;

    chk_sum_value: assert property (
        rdEvt && rdAddr == `CFT_ADDR_SUM |=> regs_r.readHold[4:0] == $past(strapQ))
        else $error("summary byte does not match straps");

    chk_sum_layout: assert property (
        rdEvt && rdAddr == `CFT_ADDR_SUM |=> regs_r.readHold[7:5] == 3'h0
            && regs_r.readHold[4] == $past(strapQ[4]) && regs_r.readHold[1] == $past(strapQ[1]))
        else $error("summary field layout wrong");

    chk_sum_dir: assert property (
        rdEvt && rdAddr == `CFT_ADDR_SUM |=> regs_r.readHold[0] == $past(strapQ[0]))
        else $error("direction bit wrong");

    chk_sum_readonly: assert property (
        goodWr && wrAddr == `CFT_ADDR_SUM |=> $stable(regs_r.wp) && $stable(regs_r.lowDac)
            && $stable(regs_r.ssfm) && $stable(regs_r.commFault))
        else $error("write to summary changed state");

    chk_fault_set: assert property (
        wrEvt && wrBad |=> regs_r.commFault ##1 commFaultFlag)
        else $error("check failure did not set fault flag");

    chk_fault_clear: assert property (
        wrCtrl && wrData[`CFT_CTRL_FAULT] |=> !regs_r.commFault)
        else $error("write one did not clear fault flag");

    chk_sticky_reset: assert property (
        wrCtrl && wrData[`CFT_CTRL_RST] |=> regs_r.lowDac == 7'h00 && regs_r.highDac == 7'h00
            && regs_r.currentSet == 5'h00 && regs_r.ssfm == 5'h00 && !regs_r.wp)
        else $error("reset bit did not restore defaults");

    chk_wp_block: assert property (
        goodWr && regs_r.wp && wrAddr != `CFT_ADDR_CTRL |=> $stable(regs_r.lowDac)
            && $stable(regs_r.highDac) && $stable(regs_r.currentSet) && $stable(regs_r.ssfm))
        else $error("protected write took effect");

    chk_wp_allow: assert property (
        wrLow && !regs_r.wp |=> regs_r.lowDac == $past(wrData[6:0]))
        else $error("low trim write lost");

    chk_low_gate: assert property (
        !strapQ[0] |=> !lowFeedbackPinEn && lowFeedbackPinUa == 8'h00)
        else $error("low trim current applied in step-up");

    chk_high_gate: assert property (
        strapQ[0] |=> !highFeedbackPinEn && highFeedbackPinUa == 8'h00)
        else $error("high trim current applied in step-down");

    chk_dac_value: assert property (
        strapQ[0] && $stable(regs_r.lowDac) |=> $signed(lowFeedbackPinUa)
            == $signed($past(regs_r.lowDac)))
        else $error("trim current not equal to signed code");

    chk_reset_vals: assert property (
        $rose(rst_n) |-> regs_r.lowDac == 7'h00 && regs_r.highDac == 7'h00
            && regs_r.currentSet == 5'h00 && regs_r.ssfm == 5'h00)
        else $error("trim registers not zero after reset");

    chk_cset_value: assert property (
        $stable(regs_r.currentSet) |=> currentSetPinUa == (($past(regs_r.currentSet[4])
            ? 5'h00 : 5'h10) + {1'b0, $past(regs_r.currentSet[3:0])}))
        else $error("current-set value wrong");

    chk_spread_map: assert property (
        regs_r.ssfm == 5'h1f ##1 regs_r.ssfm == 5'h1f |-> spreadPct == 4'h8 && modDivExp == 4'h9)
        else $error("spread code map wrong");

    chk_rsvd_zero: assert property (
        rdEvt && rdAddr inside {`CFT_ADDR_LOW, `CFT_ADDR_HIGH} |=> regs_r.readHold[7] == 1'b0)
        else $error("reserved bit read as one");

    cov_bad_pec: cover property (wrEvt && wrBad);
    cov_wp_write: cover property (wrLow && regs_r.wp);
    cov_sticky: cover property (wrCtrl && wrData[`CFT_CTRL_RST]);
    cov_sum_read: cover property (rdEvt && rdAddr == `CFT_ADDR_SUM);
endmodule

/* File: tb/cft_host.sv */
// serial port host model that frames register reads and writes
`timescale 1ns/1ns
module cft_host (
    output logic           sck,
    output logic           chipSel_n,
    output logic           sdi,
    input  wire logic      sdo
);
    initial begin
        sck = 1'b0;
        chipSel_n = 1'b1;
        sdi = 1'b0;
    end

    // packet check over command and data bytes, msb first
    function automatic logic [7:0] pecOf(input logic [15:0] m);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 15; i >= 0; i--) begin
            c = (c[7] ^ m[i]) ? ({c[6:0], 1'b0} ^ 8'h07) : {c[6:0], 1'b0};
        end
        return c;
    endfunction

    // sck stands still outside frames; data captured before each late rising edge
    task automatic xfer(input logic [23:0] f, output logic [7:0] rd);
        rd = 8'h00;
        #7;
        chipSel_n = 1'b0;
        for (int i = 23; i >= 0; i--) begin
            sdi = f[i];
            #63;
            if (i < 8) begin
                rd = {rd[6:0], sdo};
            end
            sck = 1'b1;
            #62;
            sck = 1'b0;
        end
        #63;
        chipSel_n = 1'b1;
        sdi = ~sdi;
        #250;
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] d, input logic bad);
        logic [7:0] p;
        logic [7:0] rd;
        p = pecOf({a, 1'b0, d}) ^ {7'h00, bad};
        xfer({a, 1'b0, d, p}, rd);
    endtask

    task automatic rdReg(input logic [6:0] a, output logic [7:0] d);
        xfer({a, 1'b1, 16'h0000}, d);
    endtask
endmodule

/* File: tb/tb_converter_config_trim_registers.sv */
// self-checking bench of the trim register bank
`timescale 1ns/1ns
`include "cft_defines.svh"
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_fail++; \
    $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module tb_converter_config_trim_registers;
    logic       clk;
    logic       rst_n;
    logic       pulseSkipFlag;
    logic       discontinuousFlag;
    logic       highImpedanceFlag;
    logic       spreadActiveFlag;
    logic       stepDownPin;
    wire        sck;
    wire        chipSel_n;
    wire        sdi;
    wire        sdo;
    wire        sdoOe_n;
    logic [7:0] lowFeedbackPinUa;
    logic       lowFeedbackPinEn;
    logic [7:0] highFeedbackPinUa;
    logic       highFeedbackPinEn;
    logic [4:0] currentSetPinUa;
    logic [3:0] spreadPct;
    logic [3:0] modDivExp;
    logic       commFaultFlag;
    int         n_fail;
    int         total_checks;
    int         seed;
    logic [4:0] s;
    logic [6:0] code;
    logic       sd;

    cft_regs DUT (.clk(clk), .rst_n(rst_n), .sck(sck), .chipSel_n(chipSel_n), .sdi(sdi),
        .pulseSkipFlag(pulseSkipFlag), .discontinuousFlag(discontinuousFlag),
        .highImpedanceFlag(highImpedanceFlag), .spreadActiveFlag(spreadActiveFlag),
        .stepDownPin(stepDownPin), .sdo(sdo), .sdoOe_n(sdoOe_n),
        .lowFeedbackPinUa(lowFeedbackPinUa), .lowFeedbackPinEn(lowFeedbackPinEn),
        .highFeedbackPinUa(highFeedbackPinUa), .highFeedbackPinEn(highFeedbackPinEn),
        .currentSetPinUa(currentSetPinUa), .spreadPct(spreadPct), .modDivExp(modDivExp),
        .commFaultFlag(commFaultFlag));

    cft_host host (.sck(sck), .chipSel_n(chipSel_n), .sdi(sdi), .sdo(sdo));

    always #10 clk = ~clk;

    function automatic logic [7:0] dacUa(input logic [6:0] c, input logic en);
        return en ? {c[6], c} : 8'h00;
    endfunction

    function automatic logic [4:0] csetUa(input logic [4:0] c);
        return (c[4] ? 5'h00 : 5'h10) + {1'b0, c[3:0]};
    endfunction

    function automatic logic [3:0] pctOf(input logic [1:0] c);
        logic [3:0] t [4];
        t = '{4'hc, 4'hf, 4'ha, 4'h8};
        return t[c];
    endfunction

    function automatic logic [3:0] divOf(input logic [2:0] c);
        logic [3:0] t [8];
        t = '{4'h9, 4'ha, 4'hb, 4'hc, 4'h8, 4'h7, 4'h6, 4'h9};
        return t[c];
    endfunction

    task automatic rdChk(input string nm, input logic [6:0] a, input logic [7:0] e);
        logic [7:0] d;
        host.rdReg(a, d);
        `CHK(nm, e, d)
    endtask

    task automatic setStraps(input logic [4:0] v);
        @(posedge clk);
        {pulseSkipFlag, discontinuousFlag, highImpedanceFlag, spreadActiveFlag, stepDownPin} <= v;
        repeat (4) @(posedge clk);
    endtask

    task automatic endTest(input string nm);
        $display("test %s done, %0d mismatches so far", nm, n_fail);
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        #1500000;
        n_fail++;
        $display("watchdog expired");
        conclude();
    end

    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        {pulseSkipFlag, discontinuousFlag, highImpedanceFlag, spreadActiveFlag,
         stepDownPin} = 5'h00;
        n_fail = 0;
        total_checks = 0;
        seed = 32'h79a5;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge clk);
        // reset values
        for (int a = 8; a < 12; a++) begin
            rdChk("trim reset", 7'(a), 8'h00);
        end
        rdChk("ctrl reset", `CFT_ADDR_CTRL, 8'h00);
        `CHK("cset reset", 5'h10, currentSetPinUa)
        `CHK("pct reset", 4'hc, spreadPct)
        `CHK("div reset", 4'h9, modDivExp)
        `CHK("oe idle", 1'b1, sdoOe_n)
        `CHK("sdo idle", 1'b0, sdo)
        endTest("reset");
        // strap summary, read-only, reserved bits
        for (int k = 0; k < 8; k++) begin
            s = (k == 0) ? 5'h1f : 5'($random(seed));
            setStraps(s);
            rdChk("summary", `CFT_ADDR_SUM, {3'b000, s});
            host.wr(`CFT_ADDR_SUM, ~{3'b000, s}, 1'b0);
            rdChk("summary ro", `CFT_ADDR_SUM, {3'b000, s});
        end
        endTest("summary");
        // voltage trims with corner codes, direction gating
        for (int k = 0; k < 12; k++) begin
            code = (k == 0) ? 7'h40 : (k == 1) ? 7'h5f : (k == 2) ? 7'h3f : 7'($random(seed));
            sd = (k < 3) ? k[0] : 1'($random(seed));
            setStraps({4'($random(seed)), sd});
            host.wr(`CFT_ADDR_LOW, {1'b1, code}, 1'b0);
            host.wr(`CFT_ADDR_HIGH, {1'b1, ~code}, 1'b0);
            `CHK("low ua", dacUa(code, sd), lowFeedbackPinUa)
            `CHK("low en", sd, lowFeedbackPinEn)
            `CHK("high ua", dacUa(~code, ~sd), highFeedbackPinUa)
            `CHK("high en", ~sd, highFeedbackPinEn)
            if (k == 1) `CHK("low top neg", 8'hdf, lowFeedbackPinUa)
            if (k == 2) `CHK("high most neg", 8'hc0, highFeedbackPinUa)
            rdChk("low rd", `CFT_ADDR_LOW, {1'b0, code});
            rdChk("high rd", `CFT_ADDR_HIGH, {1'b0, ~code});
        end
        endTest("trim");
        // every current-set and spread code
        for (int c = 0; c < 32; c++) begin
            host.wr(`CFT_ADDR_CSET, {3'b111, 5'(c)}, 1'b0);
            host.wr(`CFT_ADDR_SSFM, {3'b111, 5'(c)}, 1'b0);
            `CHK("cset ua", csetUa(5'(c)), currentSetPinUa)
            `CHK("pct", pctOf(2'(c >> 3)), spreadPct)
            `CHK("div", divOf(3'(c)), modDivExp)
        end
        rdChk("ssfm rd", `CFT_ADDR_SSFM, 8'h1f);
        rdChk("cset rd", `CFT_ADDR_CSET, 8'h1f);
        endTest("cset spread");
        // write protection
        for (int a = 8; a < 12; a++) begin
            host.wr(7'(a), 8'h0a, 1'b0);
        end
        host.wr(`CFT_ADDR_CTRL, 8'h01, 1'b0);
        rdChk("ctrl wp", `CFT_ADDR_CTRL, 8'h01);
        for (int a = 8; a < 12; a++) begin
            host.wr(7'(a), 8'h15, 1'b0);
            rdChk("wp held", 7'(a), 8'h0a);
        end
        host.wr(`CFT_ADDR_CTRL, 8'h00, 1'b0);
        for (int a = 8; a < 12; a++) begin
            host.wr(7'(a), 8'h15, 1'b0);
            rdChk("wp off", 7'(a), 8'h15);
        end
        endTest("protect");
        // register reset bit, also with protection requested
        host.wr(`CFT_ADDR_CTRL, 8'h03, 1'b0);
        for (int a = 8; a < 12; a++) begin
            rdChk("rst bit", 7'(a), 8'h00);
        end
        rdChk("ctrl after rst", `CFT_ADDR_CTRL, 8'h00);
        `CHK("cset after rst", 5'h10, currentSetPinUa)
        endTest("reset bit");
        // bad packet check sets fault, host clears by writing 1
        host.wr(`CFT_ADDR_LOW, 8'h22, 1'b1);
        rdChk("bad pec low", `CFT_ADDR_LOW, 8'h00);
        `CHK("fault set", 1'b1, commFaultFlag)
        rdChk("ctrl fault", `CFT_ADDR_CTRL, 8'h04);
        host.wr(`CFT_ADDR_CTRL, 8'h04, 1'b0);
        `CHK("fault clr", 1'b0, commFaultFlag)
        rdChk("ctrl clr", `CFT_ADDR_CTRL, 8'h00);
        endTest("fault");
        conclude();
    end
endmodule
